// File: rtl/sswd_pkg.sv
// Constants of the supply supervisor and watchdog core.
// Assumes one free-running 250 MHz clock and synchronous inputs.
// Overview of operation
// [R01] Reset output is held low while the supply is below threshold.
// [R02] Reset stays low 200 ms after the supply returns above threshold.
// [R03] The active-high reset is always the inverse of the active-low one.
// [R04] An enabled watchdog with no input transition for 1.6 s pulses reset.
// [R05] Every rising or falling input transition restarts the watchdog count.
// [R06] The host must toggle the watchdog input within the minimum timeout.
// [R07] A stuck watchdog input gives one reset pulse per 1.6 s timeout.
// [R08] A floating or mid-level watchdog input disables the watchdog.
// [R09] The host may disable the watchdog by tri-stating its drive.
// [R10] Main supply feeds the backed output above threshold, else the higher.
// [R11] The power-fail flag is low while the sense is below reference.
// [R12] In backup mode the power-fail flag and reset are held low.
// [R13] In backup mode the watchdog produces no reset pulses.
// [R14] Each watchdog reset pulse holds reset low for 200 ms.
// [R15] All long intervals come from a tick counter with a set divisor.
// [R16] Watchdog and supply inputs pass two flip-flops before any decision.
package sswd_pkg;
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned TICK_HZ = 1_000;
    localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
    localparam int unsigned RST_HOLD_MS = 200;
    localparam int unsigned WD_TIMEOUT_MS = 1_600;
    localparam int unsigned RST_HOLD_TICKS = RST_HOLD_MS * TICK_HZ / 1_000;
    localparam int unsigned WD_TICKS = WD_TIMEOUT_MS * TICK_HZ / 1_000;
    localparam int unsigned CNT_W = 18;
    localparam int unsigned MS_W = 12;
    localparam logic [1:0] SYNC_RST = 2'h0;
endpackage

// File: rtl/sswd_top.sv
// Digital core of a supply supervisor with watchdog and battery switchover.
// Assumes analog comparators deliver logic levels, all inputs synchronous.
`timescale 1ns/1ps
module sswd_top #(
    parameter int unsigned TICK_DIV = sswd_pkg::TICK_DIV,
    parameter int unsigned RST_HOLD_TICKS = sswd_pkg::RST_HOLD_TICKS,
    parameter int unsigned WD_TICKS = sswd_pkg::WD_TICKS
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic supply_low_i,
    input wire logic battery_above_supply_i,
    input wire logic power_fail_sense_i,
    input wire logic watchdog_kick_input_i,
    input wire logic watchdog_float_i,
    output logic reset_n_o,
    output logic reset_o,
    output logic power_fail_flag_n_o,
    output logic backed_supply_out_o
);
    logic [1:0] sup_s_r, bat_s_r, pfs_s_r, wdi_s_r, flt_s_r;
    logic wdi_d_r;
    logic [sswd_pkg::CNT_W-1:0] div_r;
    logic tick_r;
    logic [sswd_pkg::MS_W-1:0] hold_r, wd_r;
    logic reset_n_r, reset_r, pff_n_r, backed_r;

    // [R16] two-stage synchronisers; only stage 2 is read downstream,
    // so a metastable first stage never reaches the decision logic
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sup_s_r <= 2'h3;
            bat_s_r <= sswd_pkg::SYNC_RST;
            pfs_s_r <= sswd_pkg::SYNC_RST;
            wdi_s_r <= sswd_pkg::SYNC_RST;
            flt_s_r <= 2'h3;
        end else begin
            sup_s_r <= {sup_s_r[0], supply_low_i};
            bat_s_r <= {bat_s_r[0], battery_above_supply_i};
            pfs_s_r <= {pfs_s_r[0], power_fail_sense_i};
            wdi_s_r <= {wdi_s_r[0], watchdog_kick_input_i};
            flt_s_r <= {flt_s_r[0], watchdog_float_i};
        end
    end

    wire sup_low = sup_s_r[1];
    wire backup = sup_low && bat_s_r[1];
    wire watchdog_kick_input = wdi_s_r[1];
    wire wd_off = flt_s_r[1] || backup; // [R08] [R13]
    wire kick = watchdog_kick_input ^ wdi_d_r; // [R05]
    wire wd_fire = !wd_off && !kick && tick_r
                   && (wd_r == sswd_pkg::MS_W'(WD_TICKS - 1)); // [R04] [R07]
    wire holding = hold_r != '0;
    wire rst_nxt_n = !sup_low && !holding && !wd_fire; // [R01] [R12]

    // [R15] millisecond tick from the system clock
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_r <= '0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= div_r == sswd_pkg::CNT_W'(TICK_DIV - 1);
            if (div_r == sswd_pkg::CNT_W'(TICK_DIV - 1))
                div_r <= '0;
            else
                div_r <= div_r + 1'b1;
        end
    end

    // Hold counter restarts while supply is low or a watchdog pulse starts
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_r <= sswd_pkg::MS_W'(RST_HOLD_TICKS);
        end else if (sup_low || wd_fire) begin
            hold_r <= sswd_pkg::MS_W'(RST_HOLD_TICKS); // [R02] [R14]
        end else if (tick_r && holding) begin
            hold_r <= hold_r - 1'b1;
        end
    end

    // Watchdog count is held at zero while reset is active, so a stuck input
    // gives one pulse per full timeout after each release
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wd_r <= '0;
            wdi_d_r <= 1'b0;
        end else begin
            wdi_d_r <= watchdog_kick_input;
            if (kick || wd_off || !reset_n_r || wd_fire)
                wd_r <= '0; // [R05]
            else if (tick_r)
                wd_r <= wd_r + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reset_n_r <= 1'b0;
            reset_r <= 1'b1;
            pff_n_r <= 1'b0;
            backed_r <= 1'b0;
        end else begin
            reset_n_r <= rst_nxt_n;
            reset_r <= !rst_nxt_n; // [R03]
            pff_n_r <= !backup && pfs_s_r[1]; // [R11] [R12]
            backed_r <= backup; // [R10]
        end
    end

    assign reset_n_o = reset_n_r;
    assign reset_o = reset_r;
    assign power_fail_flag_n_o = pff_n_r;
    assign backed_supply_out_o = backed_r;

    a_reset_inverse: assert property ( // [R03]
        @(posedge ref_clk_i) disable iff (!rst_n_i) reset_o == !reset_n_o)
        else $error("reset outputs not complementary");
    a_low_supply_rst: assert property ( // [R01]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        sup_low |=> !reset_n_o)
        else $error("reset released with supply low");
    a_backup_pff_low: assert property ( // [R12]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        backup |=> !power_fail_flag_n_o && !reset_n_o)
        else $error("backup mode flags not low");
    a_pff_follows: assert property ( // [R11]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !backup |=> power_fail_flag_n_o == $past(pfs_s_r[1]))
        else $error("power fail flag mismatch");
    a_backed_select: assert property ( // [R10]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        backed_supply_out_o |-> $past(sup_low) && $past(bat_s_r[1]))
        else $error("battery selected wrongly");
    a_wd_disabled: assert property ( // [R08] [R13]
        @(posedge ref_clk_i) disable iff (!rst_n_i) wd_off |-> !wd_fire)
        else $error("watchdog fired while disabled");
    a_kick_clears: assert property ( // [R05]
        @(posedge ref_clk_i) disable iff (!rst_n_i) kick |=> wd_r == '0)
        else $error("kick did not restart watchdog");
    sequence s_fire;
        wd_fire;
    endsequence
    sequence s_pulse;
        !reset_n_o ##1 (hold_r == sswd_pkg::MS_W'(RST_HOLD_TICKS));
    endsequence
    a_wd_pulse: assert property ( // [R04] [R14]
        @(posedge ref_clk_i) disable iff (!rst_n_i) s_fire |=> s_pulse)
        else $error("watchdog pulse not started");
    a_hold_release: assert property ( // [R02]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        holding |=> !reset_n_o)
        else $error("reset released during hold");
    a_timeout_count: assert property ( // [R07]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        wd_r < sswd_pkg::MS_W'(WD_TICKS))
        else $error("watchdog count overran");
    // A disabled watchdog must not keep counting, or re-enabling it
    // would fire early on a stale count
    a_wd_frozen_off: assert property ( // [R08] [R13]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        wd_off |=> wd_r == '0)
        else $error("watchdog counted while disabled");
    a_tick_wrap: assert property ( // [R15]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        tick_r |-> div_r == '0)
        else $error("tick out of phase with divider");
    a_sync_stages: assert property ( // [R16]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        supply_low_i |-> ##2 sup_low)
        else $error("supply sync latency wrong");
    a_hold_reload: assert property ( // [R02]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        sup_low |=> hold_r == sswd_pkg::MS_W'(RST_HOLD_TICKS))
        else $error("hold count not reloaded");
    a_release_end: assert property ( // [R02] [R14]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(reset_n_o) |-> $past(hold_r) == '0 && $past(sup_low) == 1'b0)
        else $error("reset released before hold ended");
    a_wd_step: assert property ( // [R04]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        tick_r && !kick && !wd_off && reset_n_r && !wd_fire
        |=> wd_r == $past(wd_r) + 1'b1)
        else $error("watchdog count missed a tick");
endmodule

// File: tb/sswd_host.sv
// Host model: kicks the watchdog line or lets it stall.
// Assumes the bench clock; drives at the falling edge like the bench.
`timescale 1ns/1ps
module sswd_host (
    input wire logic clk_i,
    input wire logic kick_en_i,
    input wire logic tristate_i,
    output logic kick_o,
    output logic float_o
);
    logic [2:0] gap_r = 3'h0;
    initial kick_o = 1'h0;
    // Every 8 cycles, well inside the 24-cycle timeout
    always @(negedge clk_i) begin
        gap_r <= gap_r + 3'h1;
        if (kick_en_i && gap_r == 3'h7) begin
            kick_o <= ~kick_o;
        end
    end
    // Released drive holds its level so a blind core would still time out
    assign float_o = tristate_i;
endmodule

// File: tb/tb.sv
// Bench for the supervisor core with shortened tick and hold counts.
// Assumes one clock; inputs change at the falling edge.
`timescale 1ns/1ps
module tb;
    logic clk = 1'h0, rst_n = 1'h0, sup_lo = 1'h0, bat_hi = 1'h0;
    logic pf_s = 1'h1, kick_en = 1'h1, tri_en = 1'h0, kick, flt;
    logic rst_n_o, rst_o, pff_n, backed;
    int mismatches, n_compared, n;
    sswd_top #(.TICK_DIV(4), .RST_HOLD_TICKS(3), .WD_TICKS(6)) dut_u (
        .ref_clk_i(clk), .rst_n_i(rst_n), .supply_low_i(sup_lo),
        .battery_above_supply_i(bat_hi), .power_fail_sense_i(pf_s),
        .watchdog_kick_input_i(kick), .watchdog_float_i(flt),
        .reset_n_o(rst_n_o), .reset_o(rst_o),
        .power_fail_flag_n_o(pff_n), .backed_supply_out_o(backed));
    sswd_host host_u (.clk_i(clk), .kick_en_i(kick_en),
        .tristate_i(tri_en), .kick_o(kick), .float_o(flt));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Falling edges until reset_n_o shows lvl; lim+1 when it never does
    task automatic wait_rst(input logic lvl, input int lim);
        n = 0;
        while (rst_n_o !== lvl && n <= lim) begin
            @(negedge clk);
            n++;
        end
        chk(rst_o, ~rst_n_o);
    endtask
    task automatic t_supply_dip();
        sup_lo = 1'h1;
        wait_rst(1'h0, 6);
        chk(n >= 2 && n <= 4, 1'h1);
        repeat (20) @(negedge clk);
        chk(rst_n_o, 1'h0);
        chk(backed, 1'h0);
        sup_lo = 1'h0;
        wait_rst(1'h1, 40);
        chk(n >= 12 && n <= 22, 1'h1);
    endtask
    task automatic t_backup();
        sup_lo = 1'h1;
        bat_hi = 1'h1;
        repeat (40) @(negedge clk);
        chk(backed, 1'h1);
        chk(pff_n, 1'h0);
        chk(rst_n_o, 1'h0);
        sup_lo = 1'h0;
        repeat (5) @(negedge clk);
        chk(backed, 1'h0);
        bat_hi = 1'h0;
        wait_rst(1'h1, 40);
    endtask
    task automatic t_power_fail();
        pf_s = 1'h0;
        repeat (5) @(negedge clk);
        chk(pff_n, 1'h0);
        pf_s = 1'h1;
        repeat (5) @(negedge clk);
        chk(pff_n, 1'h1);
    endtask
    task automatic t_watchdog();
        kick_en = 1'h0;
        wait_rst(1'h0, 40);
        chk(n <= 34, 1'h1);
        wait_rst(1'h1, 30);
        chk(n >= 12 && n <= 18, 1'h1);
        wait_rst(1'h0, 40);
        chk(n >= 22 && n <= 32, 1'h1);
        wait_rst(1'h1, 30);
        kick_en = 1'h1;
        wait_rst(1'h0, 100);
        chk(n > 100, 1'h1);
        kick_en = 1'h0;
        tri_en = 1'h1;
        wait_rst(1'h0, 100);
        chk(n > 100, 1'h1);
    endtask
    task automatic stop_test();
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'h1;
        wait_rst(1'h1, 40);
        chk(n >= 12 && n <= 22, 1'h1);
        t_supply_dip();
        t_backup();
        t_power_fail();
        t_watchdog();
        stop_test();
    end
    // Whole run needs under 800 cycles
    initial begin
        #20000;
        mismatches++;
        stop_test();
    end
endmodule
